// ### core/i2c_switch_defines.svh
// Constants of the I2C four-channel switch control
`ifndef I2C_SWITCH_DEFINES_SVH
`define I2C_SWITCH_DEFINES_SVH

`define CHSEL_RESET 8'h00
`define CHSEL_WR_MASK 8'h0f
`define ADDR_FIXED 4'he
`define RW_BIT 0
`define CHANNELS 4
`define RESET_PULSE_NS 20
`define CLK_PERIOD_NS 20
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### core/i2c_switch_pkg.sv
// Types of the I2C four-channel switch control
package i2c_switch_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b011,
      ST_WDAT = 3'b010,
      ST_WACK = 3'b110,
      ST_RDAT = 3'b111,
      ST_RACK = 3'b101
   } i2c_state_e;
endpackage

// ### core/sync2.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/10ps
module sync2 #(
   parameter logic INIT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level
   input wire logic din,
   output logic dout
);
   logic meta_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= INIT;
         dout <= INIT;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule // sync2

// ### core/i2c_four_channel_switch_ctrl.sv
// Control logic of the I2C four-channel bus switch
`timescale 1ns/10ps
`include "i2c_switch_defines.svh"
module i2c_four_channel_switch_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic resetN,
   input wire logic powerGood,
   // Upstream bus
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Address select pins
   input wire logic addr_sel_pin_2,
   input wire logic addr_sel_pin_1,
   input wire logic addr_sel_pin_0,
   // Interrupts
   input wire logic [3:0] downstream_irq_in_n,
   output logic irqOut,
   output logic irqOe,
   // Channel switch controls
   output logic [3:0] channelConnect,
   output logic [7:0] channelSelect
);
   logic scl, sda, rstnS, pgS;
   logic [3:0] irqS;
   logic sclPrev_ff, sdaPrev_ff;
   logic devRst;
   logic startEv, stopEv, sclRise, sclFall;
   i2c_switch_pkg::i2c_state_e state_ff, nxt_state;
   logic [3:0] bitCnt_ff;
   logic inByte, byteEnd;
   logic [7:0] shift_ff;
   logic [7:0] chsel_ff;
   logic [3:0] conn_ff;
   logic pending_ff;
   logic sdaLow_ff;
   logic [2:0] addrPins;
   logic addrMatch;
   logic [2:0] pinsMeta_ff;
   logic [2:0] pinsLatched_ff;

   // Pins cross into clk domain
   sync2 #(.INIT(1'b1)) u_scl (.clk(clk), .rst(rst), .din(sclIn),
      .dout(scl));
   sync2 #(.INIT(1'b1)) u_sda (.clk(clk), .rst(rst), .din(sdaIn),
      .dout(sda));
   sync2 #(.INIT(1'b0)) u_rstn (.clk(clk), .rst(rst), .din(resetN),
      .dout(rstnS));
   sync2 #(.INIT(1'b0)) u_pg (.clk(clk), .rst(rst), .din(powerGood),
      .dout(pgS));
   genvar gi;
   generate
      for (gi = 0; gi < `CHANNELS; gi++) begin : g_irq
         sync2 #(.INIT(1'b1)) u_irq (.clk(clk), .rst(rst),
            .din(downstream_irq_in_n[gi]), .dout(irqS[gi]));
      end
   endgenerate

   // A 20ns pulse is one clock here; two-flop sync may miss it
   // if it falls between edges, so the pin filter is the limit.
   assign devRst = rst | ~rstnS | ~pgS;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end else begin
         sclPrev_ff <= scl;
         sdaPrev_ff <= sda;
      end
   end

   // Data change while clock high is a control condition
   assign startEv = scl & sclPrev_ff & sdaPrev_ff & ~sda;
   assign stopEv = scl & sclPrev_ff & ~sdaPrev_ff & sda;
   assign sclRise = scl & ~sclPrev_ff;
   assign sclFall = ~scl & sclPrev_ff;

   // Straps are pins: two flops before the compare
   always_ff @(posedge clk) begin
      if (rst) begin
         pinsMeta_ff <= 3'h0;
         pinsLatched_ff <= 3'h0;
      end else begin
         pinsMeta_ff <= {addr_sel_pin_2, addr_sel_pin_1,
            addr_sel_pin_0};
         pinsLatched_ff <= pinsMeta_ff;
      end
   end
   assign addrPins = pinsLatched_ff;
   assign addrMatch = shift_ff[7:1] == {`ADDR_FIXED, addrPins};

   // Byte ends at the fall after its eighth rise
   assign inByte = state_ff == i2c_switch_pkg::ST_ADDR ||
      state_ff == i2c_switch_pkg::ST_WDAT ||
      state_ff == i2c_switch_pkg::ST_RDAT;
   assign byteEnd = inByte && sclFall && bitCnt_ff == 4'h8;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         i2c_switch_pkg::ST_IDLE: nxt_state = state_ff;
         i2c_switch_pkg::ST_ADDR:
            if (byteEnd) begin
               if (addrMatch) begin
                  nxt_state = i2c_switch_pkg::ST_AACK;
               end else begin
                  nxt_state = i2c_switch_pkg::ST_IDLE;
               end
            end
         i2c_switch_pkg::ST_AACK:
            if (sclFall) begin
               if (shift_ff[`RW_BIT]) begin
                  nxt_state = i2c_switch_pkg::ST_RDAT;
               end else begin
                  nxt_state = i2c_switch_pkg::ST_WDAT;
               end
            end
         i2c_switch_pkg::ST_WDAT:
            if (byteEnd) begin
               nxt_state = i2c_switch_pkg::ST_WACK;
            end
         i2c_switch_pkg::ST_WACK:
            if (sclFall) begin
               nxt_state = i2c_switch_pkg::ST_WDAT;
            end
         i2c_switch_pkg::ST_RDAT:
            if (byteEnd) begin
               nxt_state = i2c_switch_pkg::ST_RACK;
            end
         i2c_switch_pkg::ST_RACK:
            if (sclRise) begin
               // Not-acknowledge ends the read
               if (sda) begin
                  nxt_state = i2c_switch_pkg::ST_IDLE;
               end
            end else if (sclFall) begin
               nxt_state = i2c_switch_pkg::ST_RDAT;
            end
         default: nxt_state = i2c_switch_pkg::ST_IDLE;
      endcase
      if (startEv) begin
         nxt_state = i2c_switch_pkg::ST_ADDR;
      end else if (stopEv) begin
         nxt_state = i2c_switch_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (devRst) begin
         state_ff <= i2c_switch_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Rises are counted: the fall after start must not end a bit
   always_ff @(posedge clk) begin
      if (devRst) begin
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
      end else if (startEv) begin
         bitCnt_ff <= 4'h0;
      end else if (sclRise && inByte) begin
         bitCnt_ff <= bitCnt_ff + 4'h1;
         if (state_ff != i2c_switch_pkg::ST_RDAT) begin
            shift_ff <= {shift_ff[6:0], sda};
         end
      end else if (sclFall) begin
         if (byteEnd) begin
            bitCnt_ff <= 4'h0;
         end
         if (state_ff == i2c_switch_pkg::ST_RDAT) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
         end else if (nxt_state == i2c_switch_pkg::ST_RDAT) begin
            shift_ff <= chsel_ff;
         end
      end
   end

   // Register load after each written byte; upper bits ignored
   always_ff @(posedge clk) begin
      if (devRst) begin
         chsel_ff <= `CHSEL_RESET;
         pending_ff <= 1'b0;
      end else if (state_ff == i2c_switch_pkg::ST_WDAT && byteEnd) begin
         chsel_ff <= shift_ff & `CHSEL_WR_MASK;
         pending_ff <= 1'b1;
      end else if (stopEv || startEv) begin
         pending_ff <= 1'b0;
      end
   end

   // Switches change only at stop, or clear on reset
   always_ff @(posedge clk) begin
      if (devRst) begin
         conn_ff <= 4'h0;
      end else if (stopEv && pending_ff) begin
         conn_ff <= chsel_ff[3:0];
      end
   end

   // Data line drive, updated at clock falls and released at start or stop
   always_ff @(posedge clk) begin
      if (devRst) begin
         sdaLow_ff <= 1'b0;
      end else if (startEv || stopEv) begin
         sdaLow_ff <= 1'b0;
      end else if (sclFall) begin
         case (nxt_state)
            i2c_switch_pkg::ST_AACK,
            i2c_switch_pkg::ST_WACK: sdaLow_ff <= 1'b1;
            i2c_switch_pkg::ST_RDAT: sdaLow_ff <=
               (state_ff == i2c_switch_pkg::ST_RDAT) ? ~shift_ff[6]
               : ~chsel_ff[7];
            default: sdaLow_ff <= 1'b0;
         endcase
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = sdaLow_ff;
   assign irqOut = 1'b0;
   assign irqOe = ~devRst & ~(&irqS);
   assign channelConnect = conn_ff;
   assign channelSelect = chsel_ff;

   property p_ack_hold;
      @(posedge clk) disable iff (devRst)
      (state_ff == i2c_switch_pkg::ST_WACK && sclRise) |-> sdaOe;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("ack not driven at ninth clock");

   property p_stop_apply;
      @(posedge clk) disable iff (devRst)
      (stopEv && pending_ff) |=> channelConnect == $past(chsel_ff[3:0]);
   endproperty
   a_stop_apply: assert property (p_stop_apply)
      else $error("selection not applied at stop");

   property p_no_early;
      @(posedge clk) disable iff (devRst)
      !stopEv |=> $stable(channelConnect);
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("channels changed outside stop");

   property p_upper_zero;
      @(posedge clk) disable iff (devRst)
      chsel_ff[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper bits written");

   property p_reset_clear;
      @(posedge clk) devRst |=> channelConnect == 4'h0 && chsel_ff == 8'h00
         && state_ff == i2c_switch_pkg::ST_IDLE && !sdaOe;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("reset state not initial");

   property p_irq;
      @(posedge clk) disable iff (devRst)
      irqOe == ~(&irqS);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt output mismatch");

   property p_foreign;
      @(posedge clk) disable iff (devRst)
      (state_ff == i2c_switch_pkg::ST_ADDR && byteEnd
         && !addrMatch && !startEv && !stopEv) |=> !sdaOe;
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("acked foreign address");

   property p_sda_stable;
      @(posedge clk) disable iff (devRst)
      (scl && sclPrev_ff) |-> $stable(sdaOe);
   endproperty
   a_sda_stable: assert property (p_sda_stable)
      else $error("data drive changed while clock high");

   property p_addr_ack;
      @(posedge clk) disable iff (devRst)
      (state_ff == i2c_switch_pkg::ST_AACK && sclRise) |-> sdaOe;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address ack not driven");

   property p_read_release;
      @(posedge clk) disable iff (devRst)
      state_ff == i2c_switch_pkg::ST_RACK |-> !sdaOe;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("data line held in master ack slot");

   property p_byte_len;
      @(posedge clk) disable iff (devRst)
      bitCnt_ff < 4'h9;
   endproperty
   a_byte_len: assert property (p_byte_len)
      else $error("more than eight bits in a byte");

   property p_start_addr;
      @(posedge clk) disable iff (devRst)
      startEv |=> state_ff == i2c_switch_pkg::ST_ADDR;
   endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("start not followed by address phase");
endmodule // i2c_four_channel_switch_ctrl

// ### testbench/i2c_master_model.sv
// Behavioural upstream I2C master that drives the switch
`timescale 1ns/10ps
module i2c_master_model (
   // Clock
   input wire logic clk,
   // Bus lines
   input wire logic sda,
   output logic scl,
   output logic sdaLow
);
   initial begin
      scl <= 1'b1;
      sdaLow <= 1'b0;
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   // Data moves only while the clock is low
   task automatic bitOut(logic b);
      scl <= 1'b0;
      tick(2);
      sdaLow <= !b;
      tick(2);
      scl <= 1'b1;
      tick(4);
   endtask
   // Released at the fall so the other party can answer
   task automatic bitIn(output logic b);
      scl <= 1'b0;
      sdaLow <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(2);
      b = sda;
      tick(2);
   endtask
   // Caller enters with both lines high
   task automatic start();
      sdaLow <= 1'b1;
      tick(4);
   endtask
   task automatic stop();
      scl <= 1'b0;
      tick(2);
      sdaLow <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sdaLow <= 1'b0;
      tick(8);
   endtask
   task automatic wrByte(logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitOut(d[i]);
      end
      bitIn(b);
      ack = !b;
   endtask
   task automatic rdByte(logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bitIn(d[i]);
      end
      bitOut(nack);
   endtask
endmodule // i2c_master_model

// ### testbench/tb.sv
// Self-checking bench of the I2C four-channel switch control
`timescale 1ns/10ps
module tb;
   logic clk, rst, resetN, powerGood, a2, a1, a0, sdaOut, sdaOe;
   logic irqOut, irqOe, scl, mLow, sdaIn, ack;
   logic [3:0] irqN, connect, prev;
   logic [7:0] sel, rd;
   logic [7:0] data [8] = '{8'hf1, 8'h02, 8'h04, 8'h08, 8'h0a, 8'h05,
      8'hff, 8'h00};
   int n_fail = 0;
   int n_compared = 0;
   // Open-drain wire with pull-up
   assign sdaIn = !(mLow || (sdaOe && !sdaOut));
   i2c_four_channel_switch_ctrl i2c_four_channel_switch_ctrl_i (.clk(clk),
      .rst(rst), .resetN(resetN), .powerGood(powerGood), .sclIn(scl),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_sel_pin_2(a2),
      .addr_sel_pin_1(a1), .addr_sel_pin_0(a0),
      .downstream_irq_in_n(irqN), .irqOut(irqOut), .irqOe(irqOe),
      .channelConnect(connect), .channelSelect(sel));
   i2c_master_model i2c_master_model_i (.clk(clk), .sda(sdaIn), .scl(scl),
      .sdaLow(mLow));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wrReg(logic [7:0] a, logic [7:0] d);
      i2c_master_model_i.start();
      i2c_master_model_i.wrByte(a, ack);
      chk("address ack", 8'h01, {7'h00, ack});
      i2c_master_model_i.wrByte(d, ack);
      chk("data ack", 8'h01, {7'h00, ack});
      chk("select", d & 8'h0f, sel);
      chk("pending", {4'h0, prev}, {4'h0, connect});
      i2c_master_model_i.stop();
      chk("connect", {4'h0, d[3:0]}, {4'h0, connect});
      prev = d[3:0];
   endtask
   task automatic rdReg(logic [7:0] a, logic [7:0] exp);
      i2c_master_model_i.start();
      i2c_master_model_i.wrByte(a | 8'h01, ack);
      chk("read ack", 8'h01, {7'h00, ack});
      i2c_master_model_i.rdByte(1'b1, rd);
      chk("readback", exp, rd);
      i2c_master_model_i.stop();
   endtask
   task automatic pinReset(logic viaPin);
      wrReg(8'he0, 8'h0f);
      resetN <= !viaPin;
      powerGood <= viaPin;
      // Three cycles exceed the minimum pulse width
      repeat (3) @(posedge clk);
      resetN <= 1'b1;
      powerGood <= 1'b1;
      repeat (8) @(posedge clk);
      chk("reset select", 8'h00, sel);
      chk("reset connect", 8'h00, {4'h0, connect});
      prev = 4'h0;
      $display("test reset %0d done", viaPin);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      rst <= 1'b1;
      resetN <= 1'b1;
      powerGood <= 1'b1;
      {a2, a1, a0} <= 3'h0;
      irqN <= 4'hf;
      prev = 4'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk("por select", 8'h00, sel);
      chk("por lines", 8'h00, {1'b0, sdaOut, connect, sdaOe, irqOe});
      $display("test reset values done");
      for (int s = 0; s < 8; s++) begin
         {a2, a1, a0} <= s[2:0];
         repeat (4) @(posedge clk);
         wrReg({4'he, s[2:0], 1'b0}, data[s]);
         rdReg({4'he, s[2:0], 1'b0}, data[s] & 8'h0f);
      end
      $display("test straps and channels done");
      i2c_master_model_i.start();
      i2c_master_model_i.wrByte(8'hd0 | {4'h0, a2, a1, a0, 1'b0}, ack);
      chk("foreign ack", 8'h00, {7'h00, ack});
      i2c_master_model_i.wrByte(8'h05, ack);
      i2c_master_model_i.stop();
      chk("foreign select", 8'h00, sel);
      $display("test foreign address done");
      wrReg({4'he, a2, a1, a0, 1'b0}, 8'h69);
      i2c_master_model_i.start();
      i2c_master_model_i.wrByte({4'he, a2, a1, a0, 1'b1}, ack);
      chk("burst ack", 8'h01, {7'h00, ack});
      i2c_master_model_i.rdByte(1'b0, rd);
      chk("burst first", 8'h09, rd);
      i2c_master_model_i.rdByte(1'b1, rd);
      chk("burst last", 8'h09, rd);
      i2c_master_model_i.stop();
      $display("test burst read done");
      for (int i = 0; i < 16; i++) begin
         irqN <= i[3:0];
         repeat (4) @(posedge clk);
         chk("irq", {7'h00, i != 15}, {6'h00, irqOut, irqOe});
      end
      irqN <= 4'hf;
      $display("test interrupts done");
      {a2, a1, a0} <= 3'h0;
      pinReset(1'b1);
      pinReset(1'b0);
      print_verdict();
   end
endmodule // tb
